// ===== include/urbs_defs.svh
`ifndef URBS_DEFS_SVH
`define URBS_DEFS_SVH

// Register byte offsets on the AHB-Lite bus
`define URBS_OFS_DATA 8'h00
`define URBS_OFS_STATUS 8'h04
`define URBS_OFS_CTRL_B 8'h08
`define URBS_OFS_CTRL_C 8'h0C
`define URBS_OFS_BAUD 8'h10

// Status register bit positions
`define URBS_ST_DONE 7
`define URBS_ST_FRAME 4
`define URBS_ST_OVR 3
`define URBS_ST_PAR 2

// Control register B bit positions
`define URBS_CB_IRQ_EN 7
`define URBS_CB_RX_EN 4
`define URBS_CB_SIZE2 2
`define URBS_CB_NINTH 1

// Control register C bit positions
`define URBS_CC_PM_HI 5
`define URBS_CC_PM_LO 4
`define URBS_CC_STOP 3
`define URBS_CC_SIZE_HI 2
`define URBS_CC_SIZE_LO 1

// Reset values
`define URBS_RST_CTRL_B 8'h00
`define URBS_RST_CTRL_C 8'h06
`define URBS_RST_BAUD 16'h0010

// Character size code for nine data bits
`define URBS_SIZE_NINE 3'h7

// Buffer entry layout: data in 8:0, then the three error bits
`define URBS_ENT_FRAME 9
`define URBS_ENT_OVR 10
`define URBS_ENT_PAR 11
`define URBS_ENT_W 12

`endif

// ===== include/urbs_pkg.sv
package urbs_pkg;

	// Receive frame sequencer states
	typedef enum logic [2:0] {
		RxIdle,
		RxStart,
		RxData,
		RxParity,
		RxStop
	} urbs_rx_state_t;

	// Number of data bits for a character size code
	function automatic logic [3:0] urbs_data_bits(input logic [2:0] size);
		urbs_data_bits = (size == 3'h7) ? 4'h9 : (4'h5 + {2'h0, size[1:0]});
	endfunction

	// Mask that keeps only the valid data bits
	function automatic logic [8:0] urbs_data_mask(input logic [2:0] size);
		urbs_data_mask = 9'h1FF >> (4'h9 - urbs_data_bits(size));
	endfunction

endpackage

// ===== rtl/urbs_buf_mem.sv
`timescale 1ns/1ps
// Small receive buffer store, registered read data with write forwarding
module urbs_buf_mem #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 2,
	parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
	input wire logic clk,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	logic [WIDTH-1:0] mem [DEPTH]; // Entry storage
	logic [WIDTH-1:0] rdData_reg; // Registered read port
	wire fwdHit = wrEn && (wrAddr == rdAddr); // Write to the entry being read

	// Storage write
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Read register; forwarding keeps a fresh head visible at once
	always_ff @(posedge clk) begin
		rdData_reg <= fwdHit ? wrData : mem[rdAddr];
	end

	assign rdData = rdData_reg;

endmodule

// ===== rtl/urbs_frame_rx.sv
`timescale 1ns/1ps
// Serial frame sequencer: start check, data, parity, first stop bit
module urbs_frame_rx
	import urbs_pkg::*;
#(
	parameter int DIV_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic rxd,
	input wire logic [DIV_W-1:0] bitPeriod,
	input wire logic [3:0] dataBits,
	input wire logic parityOn,
	output logic startDet,
	output logic frameDone,
	output logic [8:0] frameData,
	output logic parityBit,
	output logic stopBit
);

	urbs_rx_state_t state_reg; // Sequencer state
	logic [DIV_W-1:0] cnt_reg; // Cycles to next sample point
	logic [3:0] idx_reg; // Current data bit index
	logic rxPrev_reg; // Line level one cycle ago
	logic startDet_reg;
	logic frameDone_reg;
	logic [8:0] data_reg;
	logic parity_reg;
	logic stop_reg;

	wire sampleNow = (cnt_reg == '0); // Middle of the bit reached
	wire fallEdge = rxPrev_reg && !rxd; // Idle to start transition
	wire lastData = (idx_reg == dataBits - 4'h1); // Final data bit
	wire [DIV_W-1:0] fullBit = bitPeriod - {{(DIV_W-1){1'b0}}, 1'b1};

	// Sequencer; a cleared enable drops any frame at once
	always_ff @(posedge clk) begin
		if (!rst_n || !enable) begin
			state_reg <= RxIdle;
			cnt_reg <= '0;
			idx_reg <= 4'h0;
			rxPrev_reg <= 1'b1;
			startDet_reg <= 1'b0;
			frameDone_reg <= 1'b0;
			data_reg <= 9'h000;
			parity_reg <= 1'b0;
			stop_reg <= 1'b1;
		end else begin
			rxPrev_reg <= rxd;
			startDet_reg <= 1'b0;
			frameDone_reg <= 1'b0;
			cnt_reg <= sampleNow ? fullBit : cnt_reg - {{(DIV_W-1){1'b0}}, 1'b1};
			unique case (state_reg)
				RxIdle: begin
					// Wait half a bit then check the start bit
					if (fallEdge) begin
						state_reg <= RxStart;
						cnt_reg <= bitPeriod >> 1;
					end
				end
				RxStart: begin
					if (sampleNow) begin
						state_reg <= rxd ? RxIdle : RxData;
						startDet_reg <= !rxd;
						idx_reg <= 4'h0;
						data_reg <= 9'h000;
					end
				end
				RxData: begin
					if (sampleNow) begin
						data_reg[idx_reg] <= rxd;
						idx_reg <= idx_reg + 4'h1;
						if (lastData) begin
							state_reg <= parityOn ? RxParity : RxStop;
						end
					end
				end
				RxParity: begin
					if (sampleNow) begin
						parity_reg <= rxd;
						state_reg <= RxStop;
					end
				end
				RxStop: begin
					// Only the first stop bit is looked at
					if (sampleNow) begin
						stop_reg <= rxd;
						frameDone_reg <= 1'b1;
						state_reg <= RxIdle;
					end
				end
			endcase
		end
	end

	assign startDet = startDet_reg;
	assign frameDone = frameDone_reg;
	assign frameData = data_reg;
	assign parityBit = parity_reg;
	assign stopBit = stop_reg;

endmodule

// ===== rtl/urbs_rx_top.sv
// Notes on behaviour
// - Ninth bit and flags stored per frame
// - Receive-complete reads one while buffer nonempty
// - Clearing receiver enable flushes the buffer
// - Interrupt request follows flag when enabled
// - Error flags belong to oldest unread frame
// - Status writes leave error flags unchanged
// - Error flags raise no interrupt request
// - Frame error set when stop sampled low
// - Only first stop bit checked, count ignored
// - Overrun: buffer full, held frame, new start
// - Overrun cleared on successful buffer transfer
// - Parity error reads zero when checking off
// - Checker active on high mode bit only
// - Parity compared, result stored with frame
// - Parity error valid until data is read
// - Disable is immediate, releases receive pin
// - Frame moves to buffer after first stop
// - Unused upper data bits read as zero
`timescale 1ns/1ps
`include "urbs_defs.svh"
module urbs_rx_top
	import urbs_pkg::*;
#(
	parameter int DEPTH = 2,
	parameter int DIV_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rxdPin,
	output logic rxPinOverride,
	output logic rxIrq
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	// Pin synchroniser
	logic rxdMeta_reg; // First stage, read only by the second
	logic rxdSync_reg; // Second stage, safe to use

	// Software controls
	logic [7:0] ctrlB_reg; // Enables and size high bit
	logic [7:0] ctrlC_reg; // Parity, stop count, size low bits
	logic [DIV_W-1:0] baud_reg; // Cycles per serial bit

	// Buffer state
	logic [CW-1:0] count_reg; // Unread entries
	logic [AW-1:0] wrPtr_reg; // Next free entry
	logic [AW-1:0] rdPtr_reg; // Oldest unread entry
	logic [`URBS_ENT_W-1:0] head; // Oldest entry from the store

	// Completed frame waiting in the shift register stage
	logic holdFull_reg;
	logic [`URBS_ENT_W-1:0] hold_reg;
	logic ovrPending_reg; // Frames were lost since last transfer

	// Bus address phase capture
	logic wrPend_reg; // Write data phase pending
	logic [7:0] wrAddr_reg; // Offset of the pending write
	logic [31:0] hrdata_reg; // Read data for the data phase

	// Frame receiver outputs
	logic startDet;
	logic frameDone;
	logic [8:0] frameData;
	logic parityBit;
	logic stopBit;

	// Decoded controls
	wire rxEnable = ctrlB_reg[`URBS_CB_RX_EN];
	wire irqEnable = ctrlB_reg[`URBS_CB_IRQ_EN];
	wire [2:0] charSize = {ctrlB_reg[`URBS_CB_SIZE2], ctrlC_reg[`URBS_CC_SIZE_HI:`URBS_CC_SIZE_LO]};
	wire parityOn = ctrlC_reg[`URBS_CC_PM_HI];
	wire parityOdd = ctrlC_reg[`URBS_CC_PM_LO];
	wire [3:0] dataBits = urbs_data_bits(charSize);

	// Buffer status; the flag drops with the enable, ahead of the flush edge
	wire bufEmpty = (count_reg == '0);
	wire bufFull = (count_reg == CW'(DEPTH));
	wire rxComplete = rxEnable && !bufEmpty;

	// Head fields, zero when nothing is buffered
	wire headFrameErr = rxComplete && head[`URBS_ENT_FRAME];
	wire headOverrun = rxComplete && head[`URBS_ENT_OVR];
	wire headParErr = rxComplete && head[`URBS_ENT_PAR];
	wire headNinth = rxComplete && head[8];
	wire [7:0] headData = rxComplete ? head[7:0] : 8'h00;

	// Bus address phase decode
	wire busTake = hsel && htrans[1] && hready;
	wire [7:0] busOfs = haddr[7:0];
	wire rdTake = busTake && !hwrite;
	wire wrTake = busTake && hwrite;

	// Reading the data location pops the oldest entry
	wire pop = rdTake && (busOfs == `URBS_OFS_DATA) && rxComplete;
	wire push = holdFull_reg && (!bufFull || pop);
	wire [AW-1:0] rdPtrInc = (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + AW'(1);
	wire [AW-1:0] wrPtrInc = (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + AW'(1);
	wire [AW-1:0] rdPtrNext = pop ? rdPtrInc : rdPtr_reg;

	// Parity checked over the valid data bits only
	wire [8:0] maskedData = frameData & urbs_data_mask(charSize);
	wire parityCalc = (^maskedData) ^ parityOdd;
	wire parityErr = parityOn && (parityCalc != parityBit);
	wire frameErr = !stopBit;
	wire [`URBS_ENT_W-1:0] newEntry = {parityErr, 1'b0, frameErr, maskedData};

	// Overrun: store full, a frame held, and another start begins
	wire overrunEvt = startDet && bufFull && holdFull_reg && !push;

	// Data phase write decode; status has no writable bits
	wire wrCtrlB = wrPend_reg && (wrAddr_reg == `URBS_OFS_CTRL_B);
	wire wrCtrlC = wrPend_reg && (wrAddr_reg == `URBS_OFS_CTRL_C);
	wire wrBaud = wrPend_reg && (wrAddr_reg == `URBS_OFS_BAUD);

	// Register read multiplexer
	wire [7:0] statusVal = {rxComplete, 2'b00, headFrameErr, headOverrun, headParErr, 2'b00};
	wire [7:0] ctrlBVal = {ctrlB_reg[7:2], headNinth, ctrlB_reg[0]};
	wire [31:0] rdMux =
		(busOfs == `URBS_OFS_DATA) ? {24'h000000, headData} :
		(busOfs == `URBS_OFS_STATUS) ? {24'h000000, statusVal} :
		(busOfs == `URBS_OFS_CTRL_B) ? {24'h000000, ctrlBVal} :
		(busOfs == `URBS_OFS_CTRL_C) ? {24'h000000, ctrlC_reg} :
		(busOfs == `URBS_OFS_BAUD) ? {{(32-DIV_W){1'b0}}, baud_reg} : 32'h00000000;

	// Two-flop synchroniser for the serial line
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxdMeta_reg <= 1'b1;
			rxdSync_reg <= 1'b1;
		end else begin
			rxdMeta_reg <= rxdPin;
			rxdSync_reg <= rxdMeta_reg;
		end
	end

	// Bus address phase capture and registered read data
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
			hrdata_reg <= 32'h00000000;
		end else begin
			wrPend_reg <= wrTake;
			wrAddr_reg <= busOfs;
			if (rdTake) begin
				hrdata_reg <= rdMux;
			end
		end
	end

	// Control registers; bit 1 of control B is read-only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrlB_reg <= `URBS_RST_CTRL_B;
			ctrlC_reg <= `URBS_RST_CTRL_C;
			baud_reg <= DIV_W'(`URBS_RST_BAUD);
		end else begin
			if (wrCtrlB) begin
				ctrlB_reg <= {hwdata[7:2], 1'b0, hwdata[0]};
			end
			if (wrCtrlC) begin
				ctrlC_reg <= hwdata[7:0];
			end
			if (wrBaud) begin
				baud_reg <= hwdata[DIV_W-1:0];
			end
		end
	end

	// Holding stage for a completed frame; a newer one overwrites it
	always_ff @(posedge clk) begin
		if (!rst_n || !rxEnable) begin
			holdFull_reg <= 1'b0;
			hold_reg <= '0;
			ovrPending_reg <= 1'b0;
		end else begin
			if (frameDone) begin
				holdFull_reg <= 1'b1;
				hold_reg <= newEntry;
			end else if (push) begin
				holdFull_reg <= 1'b0;
			end
			// Set wins; a transfer carries and clears the overrun mark
			if (overrunEvt) begin
				ovrPending_reg <= 1'b1;
			end else if (push) begin
				ovrPending_reg <= 1'b0;
			end
		end
	end

	// Buffer pointers and fill count; disable empties everything
	always_ff @(posedge clk) begin
		if (!rst_n || !rxEnable) begin
			count_reg <= '0;
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
		end else begin
			rdPtr_reg <= rdPtrNext;
			if (push) begin
				wrPtr_reg <= wrPtrInc;
			end
			if (push && !pop) begin
				count_reg <= count_reg + CW'(1);
			end else if (pop && !push) begin
				count_reg <= count_reg - CW'(1);
			end
		end
	end

	// Frame sequencer
	urbs_frame_rx #(
		.DIV_W(DIV_W)
	) u_frame_rx (
		.clk(clk),
		.rst_n(rst_n),
		.enable(rxEnable),
		.rxd(rxdSync_reg),
		.bitPeriod(baud_reg),
		.dataBits(dataBits),
		.parityOn(parityOn),
		.startDet(startDet),
		.frameDone(frameDone),
		.frameData(frameData),
		.parityBit(parityBit),
		.stopBit(stopBit)
	);

	// Entry store; the overrun mark joins the frame on transfer
	urbs_buf_mem #(
		.WIDTH(`URBS_ENT_W),
		.DEPTH(DEPTH)
	) u_buf_mem (
		.clk(clk),
		.wrEn(push),
		.wrAddr(wrPtr_reg),
		.wrData({hold_reg[`URBS_ENT_PAR], ovrPending_reg || overrunEvt, hold_reg[9:0]}),
		.rdAddr(rdPtrNext),
		.rdData(head)
	);

	// Bus answers at once, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// Pin returns to port use when the receiver is off
	assign rxPinOverride = rxEnable;

	// Request only from receive-complete, never from error flags
	assign rxIrq = irqEnable && rxComplete;

endmodule

// ===== tb/urbs_rx_props.sv
`timescale 1ns/1ps
`include "urbs_defs.svh"
// Checks bus answers, pin ownership and the receive request line
module urbs_rx_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic rxPinOverride,
	input wire logic rxIrq
);
	logic dPh; // Data phase under way
	logic dWr; // That phase writes
	logic [7:0] dAd; // Its offset
	logic ieReg; // Mirror of the request enable
	logic pmReg; // Mirror of the parity enable
	// Data-phase decodes
	wire wB = dPh && dWr && dAd == `URBS_OFS_CTRL_B;
	wire wC = dPh && dWr && dAd == `URBS_OFS_CTRL_C;
	wire rS = dPh && !dWr && dAd == `URBS_OFS_STATUS;
	wire rD = dPh && !dWr && dAd == `URBS_OFS_DATA;
	// Phase tracking and control mirrors
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dPh <= 1'b0;
			ieReg <= 1'b0;
			pmReg <= 1'b0;
		end else begin
			dPh <= hsel && htrans[1] && hready;
			if (wB) ieReg <= hwdata[`URBS_CB_IRQ_EN];
			if (wC) pmReg <= hwdata[`URBS_CC_PM_HI];
		end
	end
	// Address and direction of the pending phase
	always_ff @(posedge clk) begin
		dWr <= hwrite;
		dAd <= haddr[7:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not okay");
	pin_follow_a: assert property (wB |=> rxPinOverride == $past(hwdata[`URBS_CB_RX_EN]))
		else $error("pin ownership does not follow enable");
	irq_pin_a: assert property (rxIrq |-> rxPinOverride)
		else $error("request while receiver off");
	irq_rise_a: assert property ($rose(rxIrq) |-> ieReg)
		else $error("request without enable");
	irq_fall_a: assert property ($fell(rxIrq) |-> rD || $past(wB))
		else $error("request dropped without data read");
	flag_irq_a: assert property (rS && $past(rxIrq) |-> hrdata[`URBS_ST_DONE])
		else $error("complete flag low while request high");
	data_upper_a: assert property (rD |-> hrdata[31:9] == 23'h0)
		else $error("upper data bits not zero");
	parity_off_a: assert property (rS && !pmReg |-> !hrdata[`URBS_ST_PAR])
		else $error("parity flag with checking off");
endmodule
bind urbs_rx_top urbs_rx_props chk_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .rxPinOverride(rxPinOverride), .rxIrq(rxIrq));

// ===== tb/urbs_ser_tx.sv
`timescale 1ns/1ps
// Remote transmitter: idles at mark, sends one frame per call
module urbs_ser_tx #(
	parameter int BIT_CYC = 8
) (
	input wire logic clk,
	output logic line
);
	initial line = 1'b1; // Mark level while idle
	// One bit time at a level
	task automatic bitOut(input logic b);
		line <= b;
		repeat (BIT_CYC) @(posedge clk);
	endtask
	// Start, data LSB first, optional parity, stop, then mark
	task automatic send(input logic [8:0] d, input int nb, input logic pOn, input logic pV,
		input logic s1);
		bitOut(1'b0);
		for (int i = 0; i < nb; i++) bitOut(d[i]);
		if (pOn) bitOut(pV);
		bitOut(s1);
		bitOut(1'b1);
	endtask
endmodule

// ===== tb/uart_receive_buffer_status_bench.sv
`timescale 1ns/1ps
`include "urbs_defs.svh"
// Drives the bus and the serial line, checks reads against expectations
module uart_receive_buffer_status_bench;
	localparam int BC = 8; // Bit time in clocks
	// Frame row: format, data, faults, expected status
	typedef struct packed {
		logic [7:0] c;
		logic n9;
		logic [8:0] d;
		logic pBad;
		logic s1;
		logic [7:0] st;
	} urbs_row_t;
	urbs_row_t rows [10] = '{
		'{8'h06, 1'b0, 9'h0A5, 1'b0, 1'b1, 8'h80},
		'{8'h00, 1'b0, 9'h1FF, 1'b0, 1'b1, 8'h80},
		'{8'h02, 1'b0, 9'h0FF, 1'b0, 1'b1, 8'h80},
		'{8'h24, 1'b0, 9'h055, 1'b0, 1'b1, 8'h80},
		'{8'h24, 1'b0, 9'h055, 1'b1, 1'b1, 8'h84},
		'{8'h36, 1'b0, 9'h0C3, 1'b0, 1'b1, 8'h80},
		'{8'h36, 1'b0, 9'h0C3, 1'b1, 1'b1, 8'h84},
		'{8'h16, 1'b0, 9'h03C, 1'b0, 1'b1, 8'h80},
		'{8'h0E, 1'b0, 9'h0F0, 1'b0, 1'b0, 8'h90},
		'{8'h06, 1'b1, 9'h1A5, 1'b0, 1'b1, 8'h80}
	};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, rxdPin, rxPinOverride, rxIrq;
	logic [31:0] hrdata, cb;
	int failures = 0;
	int compares = 0;
	int nb;
	urbs_row_t r;
	logic [8:0] dm;
	logic pv;
	always #4 clk = ~clk;
	urbs_rx_top dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxdPin(rxdPin),
		.rxPinOverride(rxPinOverride), .rxIrq(rxIrq));
	urbs_ser_tx #(.BIT_CYC(BC)) peer_u (.clk(clk), .line(rxdPin));
	// Verdict and end of run
	task automatic complete_run();
		if (failures == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Wait for ready sampled high at a rising edge
	task automatic waitRdy();
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 40) begin
				failures++;
				complete_run();
			end
			@(posedge clk);
		end
	endtask
	// Single word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		waitRdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x & 32'h0FF, e);
	endtask
	// Poll status until a character is waiting
	task automatic waitDone();
		logic [31:0] x;
		int n;
		n = 0;
		x = 32'h0;
		while (x[`URBS_ST_DONE] !== 1'b1) begin
			n++;
			if (n > 300) begin
				failures++;
				complete_run();
			end
			bus(1'b0, `URBS_OFS_STATUS, 32'h0, x);
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wr(`URBS_OFS_BAUD, BC);
		// Table rows: format, frame, then status, ninth bit, data
		foreach (rows[i]) begin
			r = rows[i];
			nb = r.n9 ? 9 : 5 + r.c[2:1];
			dm = r.d & 9'((1 << nb) - 1);
			pv = ^dm ^ r.c[4] ^ r.pBad;
			cb = 32'h10 | {29'h0, r.n9, 2'h0};
			wr(`URBS_OFS_CTRL_C, {24'h0, r.c});
			wr(`URBS_OFS_CTRL_B, cb);
			peer_u.send(r.d, nb, r.c[5], pv, r.s1);
			waitDone();
			chk({31'h0, rxIrq}, 32'h0);
			rdChk(`URBS_OFS_STATUS, {24'h0, r.st});
			rdChk(`URBS_OFS_CTRL_B, cb | {30'h0, dm[8], 1'b0});
			rdChk(`URBS_OFS_DATA, {24'h0, dm[7:0]});
			rdChk(`URBS_OFS_STATUS, 32'h0);
		end
		// Two full entries, a held frame, then one that overwrites it
		wr(`URBS_OFS_CTRL_C, 32'h06);
		wr(`URBS_OFS_CTRL_B, 32'h90);
		for (int k = 1; k < 5; k++) peer_u.send(9'(k), 8, 1'b0, 1'b0, 1'b1);
		chk({31'h0, rxIrq}, 32'h1);
		wr(`URBS_OFS_STATUS, 32'h63);
		rdChk(`URBS_OFS_STATUS, 32'h80);
		rdChk(`URBS_OFS_DATA, 32'h01);
		rdChk(`URBS_OFS_STATUS, 32'h80);
		rdChk(`URBS_OFS_DATA, 32'h02);
		// Zeros written over a set overrun flag must not clear it
		wr(`URBS_OFS_STATUS, 32'h00);
		rdChk(`URBS_OFS_STATUS, 32'h88);
		rdChk(`URBS_OFS_DATA, 32'h04);
		rdChk(`URBS_OFS_STATUS, 32'h00);
		chk({31'h0, rxIrq}, 32'h0);
		peer_u.send(9'h05, 8, 1'b0, 1'b0, 1'b1);
		waitDone();
		rdChk(`URBS_OFS_STATUS, 32'h80);
		rdChk(`URBS_OFS_DATA, 32'h05);
		// Disable with one stored frame and one in flight
		peer_u.send(9'h11, 8, 1'b0, 1'b0, 1'b1);
		fork
			peer_u.send(9'h22, 8, 1'b0, 1'b0, 1'b1);
			begin
				repeat (3 * BC) @(posedge clk);
				wr(`URBS_OFS_CTRL_B, 32'h80);
				@(posedge clk);
				chk({30'h0, rxPinOverride, rxIrq}, 32'h0);
			end
		join
		wr(`URBS_OFS_CTRL_B, 32'h90);
		rdChk(`URBS_OFS_STATUS, 32'h0);
		// Reset with a stored frame, then reset values
		peer_u.send(9'h33, 8, 1'b0, 1'b0, 1'b1);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({30'h0, rxPinOverride, rxIrq}, 32'h0);
		rdChk(`URBS_OFS_STATUS, 32'h0);
		rdChk(`URBS_OFS_CTRL_B, 32'h0);
		rdChk(`URBS_OFS_CTRL_C, 32'h06);
		rdChk(`URBS_OFS_BAUD, 32'h10);
		wr(8'h14, 32'hFF);
		rdChk(8'h14, 32'h0);
		complete_run();
	end
endmodule
